// ===== src/bridge_link_diag_subsys_regs.sv
// Link diagnostic control register and subsystem alias register bank.
// Assumes a single-cycle configuration request port on clk_sys_in and
// reset pins from outside the clock domain. The training and power-state
// logic that use the field outputs sit elsewhere on the same clock.
`include "bridge_link_diag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module bridge_link_diag_subsys_regs (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        link_reset_n_in,
	input  wire logic                        global_reset_input_n_in,
	input  wire logic                        cfg_req_in,
	input  wire logic                        cfg_write_in,
	input  wire logic [11:0]                 cfg_addr_in,
	input  wire logic [3:0]                  cfg_byte_en_in,
	input  wire bridge_link_diag_pkg::cfg_word_type cfg_wdata_in,
	input  wire logic                        shared_clock_config_in,
	output logic                             cfg_ack_out,
	output logic                             cfg_hit_out,
	output bridge_link_diag_pkg::cfg_word_type cfg_rdata_out,
	output logic [7:0]                       fast_train_count_out,
	output logic [4:0]                       link_number_out,
	output logic                             l2_power_saving_enable_out,
	output logic                             first_bar_enable_out,
	output logic [15:0]                      subsystem_identifier_out,
	output logic [15:0]                      subsystem_vendor_identifier_out
);
	import bridge_link_diag_pkg::*;

	// Two-flop reset synchronisers for the link and global reset pins.
	logic [1:0]   link_rst_sync_q;
	logic [1:0]   link_rst_sync_d;
	logic [1:0]   glob_rst_sync_q;
	logic [1:0]   glob_rst_sync_d;

	// Combined field clear and decode of the current request.
	logic         field_clear;
	reg_sel_type  sel;
	logic         diag_write;
	logic         alias_write;
	logic         read_access;

	// Stored words, their merged write values and the diagnostic view.
	cfg_word_type diag_q;
	cfg_word_type diag_d;
	cfg_word_type alias_q;
	cfg_word_type alias_d;
	cfg_word_type diag_merged;
	cfg_word_type alias_merged;
	cfg_word_type diag_view;

	// Answer to the request taken at the last edge.
	cfg_word_type rdata_q;
	cfg_word_type rdata_d;
	logic         ack_q;
	logic         ack_d;
	logic         hit_q;
	logic         hit_d;

	// Reset pins are asynchronous, so each passes two flops first.
	// Only the second flop of each pair is read, which keeps a pin edge
	// that lands near the clock from reaching the field logic half-settled.
	// The synchronisers start in the asserted state so fields stay cleared
	// until both pins are seen released.
	always_comb begin
		link_rst_sync_d = {link_rst_sync_q[0], link_reset_n_in};
		glob_rst_sync_d = {glob_rst_sync_q[0], global_reset_input_n_in};
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			link_rst_sync_q <= 2'h0;
			glob_rst_sync_q <= 2'h0;
		end else begin
			link_rst_sync_q <= link_rst_sync_d;
			glob_rst_sync_q <= glob_rst_sync_d;
		end
	end

	// Any of the three resets returns every writable field to default.
	// The power-on reset is already synchronous and needs no extra flops;
	// it is folded in here so that one term drives every field clear.
	assign field_clear = !rst_n_in || !link_rst_sync_q[1] ||
		!glob_rst_sync_q[1];

	// Decode; the vendor and identifier halves share one dword at 44h,
	// so a word access there and at the alias offset reach one register.
	// The two byte-address bits are zeroed so the full offsets compare at
	// their own width; the identifier offset falls into the same dword.
	always_comb begin
		sel = sel_none_type_v;
		case ({cfg_addr_in[11:2], 2'h0})
			`DIAG_OFFSET:        sel = sel_diag_type_v;
			`ALIAS_OFFSET:       sel = sel_alias_type_v;
			`SUBSYS_VEND_OFFSET: sel = sel_alias_type_v;
			default:             sel = sel_none_type_v;
		endcase
	end

	// Strobes are qualified once here, so the storage process below only
	// chooses between keeping, merging and clearing each word.
	always_comb begin
		diag_write  = cfg_req_in && cfg_write_in &&
			(sel == sel_diag_type_v);
		alias_write = cfg_req_in && cfg_write_in &&
			(sel == sel_alias_type_v);
		read_access = cfg_req_in && !cfg_write_in;
	end

	// The revision field and bit 6 are outside the write mask.
	cfg_word_merge u_diag_merge (
		.old_in        (diag_q),
		.new_in        (cfg_wdata_in),
		.byte_en_in    (cfg_byte_en_in),
		.write_mask_in (`DIAG_WRITE_MASK),
		.merged_out    (diag_merged)
	);

	// Every alias bit is writable; the merge is shared only for the byte
	// lanes, so a partial write through 44h or 46h leaves the rest alone.
	cfg_word_merge u_alias_merge (
		.old_in        (alias_q),
		.new_in        (cfg_wdata_in),
		.byte_en_in    (cfg_byte_en_in),
		.write_mask_in (`ALIAS_WRITE_MASK),
		.merged_out    (alias_merged)
	);

	// Reads of the diagnostic word insert the fixed revision and a zero
	// bit 6. Bits 4:0 are stored as written; keeping them zero is up to
	// software and the EEPROM loader, since hardware does not police it.
	always_comb begin
		diag_view = diag_q & `DIAG_WRITE_MASK;
		diag_view[`PHY_REVISION_MSB:`PHY_REVISION_LSB] = `PHY_REVISION_VALUE;
	end

	// Storage next state. Reset wins over a write in the same cycle, so a
	// write that lands while any reset is still seen is lost on purpose;
	// software must wait for the reset pins to settle before programming.
	always_comb begin
		diag_d  = diag_q;
		alias_d = alias_q;
		if (diag_write) begin
			diag_d = diag_merged;
		end
		if (alias_write) begin
			alias_d = alias_merged;
		end
		if (field_clear) begin
			diag_d  = `DIAG_RESET;
			alias_d = `ALIAS_RESET;
		end
	end

	// Storage flops; the synchronous reset mirrors the field clear above.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			diag_q  <= `DIAG_RESET;
			alias_q <= `ALIAS_RESET;
		end else begin
			diag_q  <= diag_d;
			alias_q <= alias_d;
		end
	end

	// Answer next state. Read data is chosen from the words as they stand
	// before the edge, so a read right after a write sees the new value
	// because the write has already landed one edge earlier.
	always_comb begin
		ack_d   = cfg_req_in;
		hit_d   = hit_q;
		rdata_d = rdata_q;
		if (cfg_req_in) begin
			hit_d   = (sel != sel_none_type_v);
			rdata_d = 32'h00000000;
		end
		if (read_access) begin
			case (sel)
				sel_diag_type_v:  rdata_d = diag_view;
				sel_alias_type_v: rdata_d = alias_q;
				default:          rdata_d = 32'h00000000;
			endcase
		end
	end

	// Answer flops. Hit and read data hold until the next request so a
	// slow consumer may pick them up late; acknowledge is a single pulse.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rdata_q <= 32'h00000000;
			ack_q   <= 1'b0;
			hit_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
			hit_q   <= hit_d;
		end
	end

	// Answer ports come straight from the answer flops.
	assign cfg_ack_out   = ack_q;
	assign cfg_hit_out   = hit_q;
	assign cfg_rdata_out = rdata_q;

	// Count choice follows the link's clocking mode at all times. The mux
	// stays combinational so a mode change is seen at once; the mode bit
	// comes from a register on this same clock, so no glitch is sampled.
	assign fast_train_count_out = shared_clock_config_in ?
		diag_q[`SHR_COUNT_MSB:`SHR_COUNT_LSB] :
		diag_q[`SEP_COUNT_MSB:`SEP_COUNT_LSB];

	// Field outputs come straight from the stored flops.
	// They change on the edge that takes a write or a field clear, never in between.
	assign link_number_out = diag_q[`LINK_NUM_MSB:`LINK_NUM_LSB];
	assign l2_power_saving_enable_out = diag_q[`L2_SAVE_BIT];
	assign first_bar_enable_out = diag_q[`BAR_EN_BIT];
	assign subsystem_identifier_out = alias_q[`SUB_ID_MSB:`SUB_ID_LSB];
	assign subsystem_vendor_identifier_out =
		alias_q[`SUB_VEND_MSB:`SUB_VEND_LSB];
endmodule // bridge_link_diag_subsys_regs
`default_nettype wire

// ===== src/bridge_link_diag_cfg.svh
// Constants for the link diagnostic and subsystem alias register bank.
// Assumes byte addresses on the configuration port, one dword per register.
// Operation
// - Separate clock uses fast-train count bits 31:24.
// - Shared clock uses fast-train count bits 23:16.
// - Bit 7 enables power saving in L2.
// - Bit 6 reserved, always reads zero.
// - Bit 5 enables the first base register.
// - Link, global or power-on reset restores fields.
// - Alias bits 31:16 share subsystem identifier storage.
// - Alias bits 15:0 share subsystem vendor storage.
`ifndef BRIDGE_LINK_DIAG_CFG_SVH
`define BRIDGE_LINK_DIAG_CFG_SVH

`define DIAG_OFFSET         12'h0C8
`define ALIAS_OFFSET        12'h0D0
`define SUBSYS_VEND_OFFSET  12'h044
`define SUBSYS_ID_OFFSET    12'h046
`define FIRST_BAR_OFFSET    12'h010

`define DIAG_RESET          32'h32142000
`define ALIAS_RESET         32'h00000000
`define DIAG_WRITE_MASK     32'hFFFF1FBF
`define PHY_REVISION_VALUE  3'h1 // Arbitrary value of our own choosing.
`define ALIAS_WRITE_MASK    32'hFFFFFFFF

`define SUB_ID_MSB          31
`define SUB_ID_LSB          16
`define SUB_VEND_MSB        15
`define SUB_VEND_LSB        0

`define SEP_COUNT_MSB       31
`define SEP_COUNT_LSB       24
`define SHR_COUNT_MSB       23
`define SHR_COUNT_LSB       16
`define PHY_REVISION_MSB         15
`define PHY_REVISION_LSB         13
`define LINK_NUM_MSB        12
`define LINK_NUM_LSB        8
`define L2_SAVE_BIT         7
`define RSVD_ZERO_BIT       6
`define BAR_EN_BIT          5

`endif

// ===== src/bridge_link_diag_pkg.sv
// Types shared by the register bank files.
// Assumes the constants header is compiled alongside.
package bridge_link_diag_pkg;
	// Register selected by a configuration access, Gray ordered.
	typedef enum logic [1:0] {
		sel_none_type_v  = 2'h0,
		sel_diag_type_v  = 2'h1,
		sel_alias_type_v = 2'h3
	} reg_sel_type;

	typedef logic [31:0] cfg_word_type;
endpackage

// ===== src/cfg_word_merge.sv
// Byte-lane write merge for one configuration dword.
// Assumes the caller gives the mask of bits that software may change.
`timescale 1ns/10ps
`default_nettype none
module cfg_word_merge (
	input  wire logic [31:0] old_in,
	input  wire logic [31:0] new_in,
	input  wire logic [3:0]  byte_en_in,
	input  wire logic [31:0] write_mask_in,
	output logic      [31:0] merged_out
);
	genvar lane;
	// Each enabled lane takes new data only where the mask allows it.
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign merged_out[lane*8 +: 8] = byte_en_in[lane] ?
				((old_in[lane*8 +: 8] & ~write_mask_in[lane*8 +: 8]) |
				 (new_in[lane*8 +: 8] & write_mask_in[lane*8 +: 8])) :
				old_in[lane*8 +: 8];
		end
	endgenerate
endmodule // cfg_word_merge
`default_nettype wire

// ===== testbench/bridge_link_diag_subsys_regs_props.sv
// Checker for the link diagnostic and subsystem alias register bank.
// Assumes it sees only the bank's ports, attached by the bind below.
`timescale 1ns/10ps
`default_nettype none
module bridge_link_diag_subsys_regs_props (
	input wire logic                               clk_sys_in,
	input wire logic                               rst_n_in,
	input wire logic                               cfg_req_in,
	input wire logic                               cfg_write_in,
	input wire logic [11:0]                        cfg_addr_in,
	input wire logic [3:0]                         cfg_byte_en_in,
	input wire bridge_link_diag_pkg::cfg_word_type cfg_wdata_in,
	input wire bridge_link_diag_pkg::cfg_word_type cfg_rdata_out,
	input wire logic                               shared_clock_config_in,
	input wire logic                               cfg_ack_out,
	input wire logic                               cfg_hit_out,
	input wire logic                               l2_power_saving_enable_out,
	input wire logic                               first_bar_enable_out,
	input wire logic [7:0]                         fast_train_count_out,
	input wire logic [4:0]                         link_number_out,
	input wire logic [15:0]                        subsystem_identifier_out,
	input wire logic [15:0]                        subsystem_vendor_identifier_out
);
	// Decoded requests, so each answer is tied to the register it asked for.
	wire rd_diag = cfg_req_in && !cfg_write_in && cfg_addr_in[11:2] == 10'h032;
	wire rd_sub = cfg_req_in && !cfg_write_in &&
		cfg_addr_in[11:2] inside {10'h034, 10'h011};
	wire wr_sub = cfg_req_in && cfg_write_in &&
		cfg_addr_in[11:2] inside {10'h034, 10'h011};
	// Byte enables widened to a bit mask, and the alias word a write makes.
	wire [31:0] lane_mask = {{8{cfg_byte_en_in[3]}}, {8{cfg_byte_en_in[2]}},
		{8{cfg_byte_en_in[1]}}, {8{cfg_byte_en_in[0]}}};
	wire [31:0] sub_word = {subsystem_identifier_out,
		subsystem_vendor_identifier_out};
	wire [31:0] sub_merge = (cfg_wdata_in & lane_mask) |
		(sub_word & ~lane_mask);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_sep_count: assert property ($past(rd_diag) && !shared_clock_config_in
		|-> fast_train_count_out == cfg_rdata_out[31:24]) else $error("sep count");
	a_shared_count: assert property ($past(rd_diag) && shared_clock_config_in
		|-> fast_train_count_out == cfg_rdata_out[23:16]) else $error("shr count");
	a_l2_save_bit: assert property ($past(rd_diag)
		|-> l2_power_saving_enable_out == cfg_rdata_out[7]) else $error("l2 bit");
	a_reserved_zero: assert property ($past(rd_diag) |-> !cfg_rdata_out[6])
		else $error("bit 6 set");
	a_bar_enable: assert property ($past(rd_diag)
		|-> first_bar_enable_out == cfg_rdata_out[5]) else $error("bar bit");
	a_reset_values: assert property ($rose(rst_n_in) |-> link_number_out == 0
		&& !l2_power_saving_enable_out && !first_bar_enable_out &&
		subsystem_identifier_out == 0 && subsystem_vendor_identifier_out == 0)
		else $error("reset values");
	a_alias_write: assert property (wr_sub |=> sub_word == $past(sub_merge))
		else $error("alias write");
	a_alias_read: assert property ($past(rd_sub) |-> cfg_hit_out &&
		cfg_rdata_out == sub_word) else $error("alias read");
	a_rev_and_link: assert property ($past(rd_diag) |->
		cfg_rdata_out[15:8] == {3'h1, link_number_out}) else $error("rev/link");
endmodule // bridge_link_diag_subsys_regs_props
bind bridge_link_diag_subsys_regs bridge_link_diag_subsys_regs_props chk (.*);
`default_nettype wire

// ===== testbench/bridge_link_diag_subsys_regs_test.sv
// Self-checking bench for the link diagnostic and subsystem alias bank.
// Assumes the checker file is compiled with it and binds itself.
`timescale 1ns/10ps
`default_nettype none
module bridge_link_diag_subsys_regs_test;
	import bridge_link_diag_pkg::*;
	logic clk_sys_in = 0, rst_n_in = 0, lrst_n = 1, global_reset_input_n = 1;
	logic req = 0, wr = 0, shr = 0, ack, hit, l2, bar;
	logic [11:0] addr = 0;
	logic [3:0] be = 0;
	cfg_word_type wd = 0, rd, diag_m, sub_m, d;
	logic [7:0] ftc;
	logic [4:0] lnk;
	logic [15:0] sid, svid;
	logic [32:0] q[$];
	int errors = 0, checks = 0, cyc = 0;
	logic [11:0] tbl[5] = '{12'h0C8, 12'h0D0, 12'h044, 12'h046, 12'h0C4};
	always #5 clk_sys_in = ~clk_sys_in;
	bridge_link_diag_subsys_regs dut (.clk_sys_in, .rst_n_in,
		.link_reset_n_in(lrst_n), .global_reset_input_n_in(global_reset_input_n),
		.cfg_req_in(req), .cfg_write_in(wr), .cfg_addr_in(addr),
		.cfg_byte_en_in(be), .cfg_wdata_in(wd), .shared_clock_config_in(shr),
		.cfg_ack_out(ack), .cfg_hit_out(hit), .cfg_rdata_out(rd),
		.fast_train_count_out(ftc), .link_number_out(lnk),
		.l2_power_saving_enable_out(l2), .first_bar_enable_out(bar),
		.subsystem_identifier_out(sid), .subsystem_vendor_identifier_out(svid));
	task check(string n, logic [32:0] e, logic [32:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task close_out;
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One request per call; the shadows note what the bank should then hold.
	task access(logic w, logic [11:0] a, logic [3:0] b, cfg_word_type v);
		logic m;
		@(negedge clk_sys_in);
		{req, wr, addr, be, wd} = {1'b1, w, a, b, v};
		m = a[11:2] inside {10'h032, 10'h034, 10'h011};
		for (int i = 0; i < 4; i++)
			if (w && b[i] && a[11:2] == 10'h032)
				diag_m[8*i+:8] = v[8*i+:8];
			else if (w && b[i] && m)
				sub_m[8*i+:8] = v[8*i+:8];
		diag_m = diag_m & 32'hFFFF1FBF | 32'h00002000;
		q.push_back({m, w ? 32'h0 : a[11:2] == 10'h032 ? diag_m :
			m ? sub_m : 32'h0});
	endtask
	// Toggling the clocking mode each time exercises both counts.
	task fields;
		@(negedge clk_sys_in);
		{req, shr} = {1'b0, ~shr};
		#1;
		check("fast", shr ? diag_m[23:16] : diag_m[31:24], ftc);
		check("diag", {diag_m[7], diag_m[5], diag_m[12:8]}, {l2, bar, lnk});
		check("subsys", sub_m, {sid, svid});
	endtask
	// Answers are compared in order; a hang counts as a mismatch.
	always @(posedge clk_sys_in) begin
		#1;
		cyc++;
		if (cyc > 1000) begin
			errors++;
			close_out;
		end else if (ack === 1'b1)
			check("answer", q.pop_front(), {hit, rd});
	end
	initial begin
		void'($urandom(90));
		repeat (8) @(posedge clk_sys_in);
		@(negedge clk_sys_in) rst_n_in = 1;
		repeat (4) @(posedge clk_sys_in);
		for (int r = 0; r < 3; r++) begin
			{diag_m, sub_m} = {32'h32142000, 32'h0};
			access(0, 12'h0C8, 4'hF, 0);
			access(0, 12'h0D0, 4'hF, 0);
			fields;
			for (int i = 0; i < 15; i++) begin
				d = $urandom & 32'hFFFFFFE0;
				access(1, tbl[i % 5], 4'($urandom), d);
				access(0, tbl[(i + 1) % 5], 4'hF, 0);
				fields;
			end
			@(negedge clk_sys_in);
			{lrst_n, global_reset_input_n} = r[0] ? 2'b01 : 2'b10;
			repeat (6) @(negedge clk_sys_in);
			{lrst_n, global_reset_input_n} = 2'b11;
			repeat (4) @(negedge clk_sys_in);
		end
		// Check the last reset, then leave the diagnostic word at defaults.
		{diag_m, sub_m} = {32'h32142000, 32'h0};
		fields;
		access(1, 12'h0C8, 4'hF, 32'h32142000);
		access(0, 12'h0C8, 4'hF, 0);
		fields;
		check("pending", 0, 33'(q.size()));
		close_out;
	end
endmodule // bridge_link_diag_subsys_regs_test
`default_nettype wire
